//--- e1c_pkg.sv
// Constants shared by the E1 coding, loopback and channel 0 block
package e1c_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] IDX_CODE = 8'h15;
  localparam logic [7:0] IDX_NFA = 8'h16;
  localparam logic [7:0] IDX_AUX = 8'h17;
  localparam logic [7:0] IDX_STAT = 8'h18;
  localparam logic [7:0] ADDR_CODE = {IDX_CODE[5:0], 2'b00};
  localparam logic [7:0] ADDR_NFA = {IDX_NFA[5:0], 2'b00};
  localparam logic [7:0] ADDR_AUX = {IDX_AUX[5:0], 2'b00};
  localparam logic [7:0] ADDR_STAT = {IDX_STAT[5:0], 2'b00};
  // Coding and loopback control fields
  localparam int unsigned CODE_RX_HDB3 = 7;
  localparam int unsigned CODE_METAL = 6;
  localparam int unsigned CODE_TX_HDB3 = 5;
  localparam int unsigned CODE_DIGITAL = 3;
  localparam int unsigned CODE_REMOTE = 2;
  localparam int unsigned CODE_BPLANE = 1;
  localparam int unsigned CODE_PAYLOAD = 0;
  localparam logic [7:0] CODE_MASK = 8'hef;
  localparam logic [7:0] CODE_RST = 8'h00;
  // Non-frame-alignment control fields
  localparam int unsigned NFA_RX_ONLY = 6;
  localparam int unsigned NFA_TX_REMOTE_ALARM = 5;
  localparam int unsigned NFA_NAT_LSB = 0;
  localparam logic [7:0] NFA_MASK = 8'h7f;
  localparam logic [7:0] NFA_RST = 8'h00;
  // Auxiliary control fields
  localparam int unsigned AUX_SA_LSB = 0;
  localparam int unsigned AUX_CCS = 5;
  localparam int unsigned AUX_AUTO_REMOTE_ALARM_ENABLE = 6;
  localparam logic [7:0] AUX_MASK = 8'h7f;
  localparam logic [7:0] AUX_RST = 8'h00;
  // Status fields
  localparam int unsigned STAT_PEND = 0;
  localparam int unsigned STAT_CODE_LSB = 8;
  localparam int unsigned STAT_NFA_LSB = 16;
  localparam int unsigned STAT_AUX_LSB = 24;
  // Frame timing: 32 slots of 8 bits
  localparam logic [7:0] FRAME_LAST = 8'hff;
  localparam logic [4:0] SLOT_FRAME = 5'h00;
  localparam logic [4:0] SLOT_SIG = 5'h10;
  localparam logic [7:0] FAS_WORD = 8'h9b;
  localparam logic [1:0] NFA_FIXED = 2'h3;
  localparam int unsigned NAT_BITS = 5;
  localparam logic [1:0] ZERO_RUN_LAST = 2'h3;
  typedef enum logic [1:0] {
    SYM_NONE = 2'b00,
    SYM_MARK = 2'b01,
    SYM_VIOL = 2'b10
  } e1c_sym_t;
endpackage : e1c_pkg

//--- e1c_bit_if.sv
// Bit stream with its dual-rail line form between block and codecs
`timescale 1ns/1ps
`default_nettype none
interface e1c_bit_if;
  logic data;
  logic pos;
  logic neg;
  modport enc (input data, output pos, output neg);
  modport dec (input pos, input neg, output data);
endinterface : e1c_bit_if
`default_nettype wire

//--- e1c_hdb3_enc.sv
// Transmit line coder, HDB3 or plain AMI
`timescale 1ns/1ps
`default_nettype none
module e1c_hdb3_enc (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic bit_en,
  input wire logic hdb3_en,
  e1c_bit_if.enc lnk
);
  logic [7:0] sym;
  logic [1:0] zcnt;
  logic par;
  logic last_pol;
  logic pos_q;
  logic neg_q;
  wire sub = hdb3_en && !lnk.data && (zcnt == e1c_pkg::ZERO_RUN_LAST);
  wire [7:0] shifted = {sym[5:0], lnk.data ? e1c_pkg::SYM_MARK : e1c_pkg::SYM_NONE};
  wire [7:0] next_sym = !sub ? shifted :
                        par ? {shifted[7:2], e1c_pkg::SYM_VIOL} :
                        {e1c_pkg::SYM_MARK, shifted[5:2], e1c_pkg::SYM_VIOL};
  wire [1:0] out_sym = sym[7:6];
  wire pulse = out_sym != e1c_pkg::SYM_NONE;
  wire pol = (out_sym == e1c_pkg::SYM_MARK) ? ~last_pol : last_pol;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sym <= 8'h00;
      zcnt <= 2'h0;
      par <= 1'b0;
      last_pol <= 1'b1;
      pos_q <= 1'b0;
      neg_q <= 1'b0;
    end else if (ce && bit_en) begin
      sym <= next_sym;
      zcnt <= (lnk.data || sub) ? 2'h0 : zcnt + 2'h1;
      par <= lnk.data ? ~par : (sub ? 1'b0 : par);
      last_pol <= pulse ? pol : last_pol;
      pos_q <= pulse && pol;
      neg_q <= pulse && !pol;
    end
  end
  assign lnk.pos = pos_q;
  assign lnk.neg = neg_q;
  chk_ami_no_sub: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && bit_en && !hdb3_en) |=> (sym[1:0] != e1c_pkg::SYM_VIOL))
    else $error("violation inserted in AMI mode");
endmodule : e1c_hdb3_enc
`default_nettype wire

//--- e1c_hdb3_dec.sv
// Receive line decoder, HDB3 or plain AMI
`timescale 1ns/1ps
`default_nettype none
module e1c_hdb3_dec (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic bit_en,
  input wire logic hdb3_en,
  e1c_bit_if.dec lnk
);
  logic [3:0] sr;
  logic last_pol;
  logic data_q;
  wire pulse = lnk.pos || lnk.neg;
  wire viol = hdb3_en && pulse && (lnk.pos == last_pol);
  wire [3:0] next_sr = viol ? 4'h0 : {sr[2:0], pulse};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sr <= 4'h0;
      last_pol <= 1'b1;
      data_q <= 1'b0;
    end else if (ce && bit_en) begin
      sr <= next_sr;
      last_pol <= pulse ? lnk.pos : last_pol;
      data_q <= sr[3];
    end
  end
  assign lnk.data = data_q;
  // AMI pulses always decode as ones
  chk_ami_pulse_one: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && bit_en && !hdb3_en && pulse) |=> sr[0])
    else $error("AMI pulse not decoded as one");
endmodule : e1c_hdb3_dec
`default_nettype wire

//--- e1c_ctrl.sv
// E1 coding, loopback and channel 0 control with APB registers
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Receive coding bit one decodes HDB3, zero decodes plain AMI.
// - Transmit coding bit one applies HDB3 substitution, zero sends plain AMI.
// - Metallic loopback feeds transmit line outputs to receiver instead of line inputs.
// - Digital loopback replaces receive line output with the transmit digital stream.
// - Remote loopback sends received bipolar line data straight back out.
// - Backplane loopback connects every backplane input slot to backplane output.
// - Payload loopback returns all received slots except slot zero, and slot 16 in CAS mode, to transmit.
// - NFA-only bit makes channel 0 carry just the received NFA byte.
// - Remote alarm bit goes in A bit of NFA frame slot zero.
// - Remote alarm bit is ignored while automatic alarm enable is zero.
// - National bits fill positions four to eight of NFA slot zero.
// - Sa positions with select zero use national bits, else the data link.
// - Common channel signaling one gives CCS mode, zero gives CAS mode.
module e1c_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bit_strobe,
  input wire logic rx_line_pos,
  input wire logic rx_line_neg,
  output logic tx_line_pos,
  output logic tx_line_neg,
  input wire logic backplane_data_in,
  output logic backplane_data_out,
  input wire logic tx_ch16_data,
  input wire logic dl_data
);
  logic [7:0] code_reg;
  logic [7:0] nfa_reg;
  logic [7:0] aux_reg;
  logic [7:0] act_code;
  logic [7:0] act_nfa;
  logic [7:0] act_aux;
  logic pending;
  logic [7:0] cnt;
  logic nfas;
  logic [7:0] nfa_hold;
  logic [1:0] rxp_sync;
  logic [1:0] rxn_sync;
  logic [1:0] bpi_sync;
  logic [4:0] sa_word;

  e1c_bit_if tx_if ();
  e1c_bit_if rx_if ();

  // Pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxp_sync <= 2'h0;
      rxn_sync <= 2'h0;
      bpi_sync <= 2'h0;
    end else if (ce) begin
      rxp_sync <= {rxp_sync[0], rx_line_pos};
      rxn_sync <= {rxn_sync[0], rx_line_neg};
      bpi_sync <= {bpi_sync[0], backplane_data_in};
    end
  end
  wire rx_pos_s = rxp_sync[1];
  wire rx_neg_s = rxn_sync[1];
  wire bp_in_s = bpi_sync[1];

  // APB decode
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire hit_code = paddr == e1c_pkg::ADDR_CODE;
  wire hit_nfa = paddr == e1c_pkg::ADDR_NFA;
  wire hit_aux = paddr == e1c_pkg::ADDR_AUX;
  wire hit_stat = paddr == e1c_pkg::ADDR_STAT;
  wire mapped = hit_code || hit_nfa || hit_aux || hit_stat;
  wire wr = access && pwrite && ce;
  wire wr_code = wr && hit_code;
  wire wr_nfa = wr && hit_nfa;
  wire wr_aux = wr && hit_aux;
  wire [31:0] stat_word = {act_aux, act_nfa, act_code, 7'h00, pending};
  wire [31:0] rd_word = hit_code ? {24'h000000, code_reg} :
                        hit_nfa ? {24'h000000, nfa_reg} :
                        hit_aux ? {24'h000000, aux_reg} :
                        hit_stat ? stat_word : 32'h00000000;
  assign pready = ce;
  assign pslverr = access && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (ce && setup && !pwrite) begin
      prdata <= rd_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_reg <= e1c_pkg::CODE_RST;
      nfa_reg <= e1c_pkg::NFA_RST;
      aux_reg <= e1c_pkg::AUX_RST;
    end else begin
      if (wr_code) code_reg <= pwdata[7:0] & e1c_pkg::CODE_MASK;
      if (wr_nfa) nfa_reg <= pwdata[7:0] & e1c_pkg::NFA_MASK;
      if (wr_aux) aux_reg <= pwdata[7:0] & e1c_pkg::AUX_MASK;
    end
  end

  // Frame counter and frame parity
  wire frame_end = bit_strobe && (cnt == e1c_pkg::FRAME_LAST);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h00;
      nfas <= 1'b0;
    end else if (ce && bit_strobe) begin
      cnt <= cnt + 8'h01;
      nfas <= frame_end ? ~nfas : nfas;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_code <= e1c_pkg::CODE_RST;
      act_nfa <= e1c_pkg::NFA_RST;
      act_aux <= e1c_pkg::AUX_RST;
      pending <= 1'b0;
    end else if (ce) begin
      if (frame_end) begin
        act_code <= code_reg;
        act_nfa <= nfa_reg;
        act_aux <= aux_reg;
      end
      if (wr) pending <= 1'b1;
      else if (frame_end) pending <= 1'b0;
    end
  end

  wire rx_hdb3 = act_code[e1c_pkg::CODE_RX_HDB3];
  wire tx_hdb3 = act_code[e1c_pkg::CODE_TX_HDB3];
  wire metal = act_code[e1c_pkg::CODE_METAL];
  wire digital = act_code[e1c_pkg::CODE_DIGITAL];
  wire remote = act_code[e1c_pkg::CODE_REMOTE];
  wire bp_loop = act_code[e1c_pkg::CODE_BPLANE];
  wire payload = act_code[e1c_pkg::CODE_PAYLOAD];
  wire nfa_only = act_nfa[e1c_pkg::NFA_RX_ONLY];
  wire tx_remote_alarm = act_nfa[e1c_pkg::NFA_TX_REMOTE_ALARM];
  wire [4:0] nat = act_nfa[e1c_pkg::NFA_NAT_LSB +: e1c_pkg::NAT_BITS];
  wire [4:0] sa_sel = act_aux[e1c_pkg::AUX_SA_LSB +: e1c_pkg::NAT_BITS];
  wire ccs = act_aux[e1c_pkg::AUX_CCS];
  wire auto_remote_alarm_enable = act_aux[e1c_pkg::AUX_AUTO_REMOTE_ALARM_ENABLE];

  wire [4:0] slot = cnt[7:3];
  wire [2:0] bsel = 3'h7 - cnt[2:0];
  wire in_ts0 = slot == e1c_pkg::SLOT_FRAME;
  wire in_ts16 = slot == e1c_pkg::SLOT_SIG;

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sa
      assign sa_word[gi] = sa_sel[gi] ? dl_data : nat[gi];
    end
  endgenerate

  wire alarm_bit = auto_remote_alarm_enable && tx_remote_alarm;
  wire [7:0] nfas_word = {e1c_pkg::NFA_FIXED, alarm_bit, sa_word};
  wire [7:0] ts0_word = nfas ? nfas_word : e1c_pkg::FAS_WORD;

  assign rx_if.pos = metal ? tx_line_pos : rx_pos_s;
  assign rx_if.neg = metal ? tx_line_neg : rx_neg_s;

  e1c_hdb3_dec u_dec (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .bit_en(bit_strobe),
    .hdb3_en(rx_hdb3),
    .lnk(rx_if)
  );

  wire payload_src = payload ? rx_if.data : bp_in_s;
  wire tx_bit = in_ts0 ? ts0_word[bsel] :
                (in_ts16 && !ccs) ? tx_ch16_data : payload_src;
  wire rx_path = digital ? tx_bit : rx_if.data;
  assign tx_if.data = tx_bit;

  e1c_hdb3_enc u_enc (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .bit_en(bit_strobe),
    .hdb3_en(tx_hdb3),
    .lnk(tx_if)
  );

  wire next_bp_out = bp_loop ? bp_in_s :
                     (nfa_only && in_ts0 && !nfas) ? nfa_hold[bsel] : rx_path;
  wire next_tx_pos = remote ? rx_pos_s : tx_if.pos;
  wire next_tx_neg = remote ? rx_neg_s : tx_if.neg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nfa_hold <= 8'h00;
      backplane_data_out <= 1'b0;
      tx_line_pos <= 1'b0;
      tx_line_neg <= 1'b0;
    end else if (ce && bit_strobe) begin
      if (in_ts0 && nfas) nfa_hold <= {nfa_hold[6:0], rx_path};
      backplane_data_out <= next_bp_out;
      tx_line_pos <= next_tx_pos;
      tx_line_neg <= next_tx_neg;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  wire step = ce && bit_strobe;
  wire in_nfa_ts0 = step && in_ts0 && nfas;

  // settings change only at frame end
  chk_frame_apply: assert property ($changed(act_code) |-> $past(ce && frame_end))
    else $error("coding settings changed off frame boundary");
  chk_bp_loop_out: assert property ((step && bp_loop) |=> backplane_data_out == $past(bp_in_s))
    else $error("backplane loop output wrong");
  chk_remote_loop: assert property ((step && remote) |=>
    (tx_line_pos == $past(rx_pos_s)) && (tx_line_neg == $past(rx_neg_s)))
    else $error("remote loop output wrong");
  chk_metal_input: assert property (metal |-> (rx_if.pos == tx_line_pos) &&
    (rx_if.neg == tx_line_neg))
    else $error("metallic loop input wrong");
  chk_digital_path: assert property ((step && digital && !bp_loop && !in_ts0) |=>
    backplane_data_out == $past(tx_bit))
    else $error("digital loop path wrong");
  chk_alarm_bit: assert property ((in_nfa_ts0 && cnt[2:0] == 3'h2 && auto_remote_alarm_enable) |->
    tx_bit == tx_remote_alarm)
    else $error("A bit does not follow alarm control");
  chk_alarm_off: assert property ((in_nfa_ts0 && cnt[2:0] == 3'h2 && !auto_remote_alarm_enable) |-> !tx_bit)
    else $error("A bit sent while alarm enable is zero");
  chk_nat_bits: assert property ((in_nfa_ts0 && cnt[2:0] >= 3'h3 && !sa_sel[bsel]) |->
    tx_bit == nat[bsel])
    else $error("national bit wrong");
  chk_payload_loop: assert property ((step && payload && !in_ts0 && (!in_ts16 || ccs)) |->
    tx_bit == rx_if.data)
    else $error("payload loop slot wrong");
  // CAS places signaling in slot 16
  chk_cas_slot16: assert property ((step && in_ts16 && !ccs) |-> tx_bit == tx_ch16_data)
    else $error("slot 16 not signaling in CAS mode");
  chk_nfa_only: assert property ((step && nfa_only && !bp_loop && in_ts0 && !nfas) |=>
    backplane_data_out == $past(nfa_hold[bsel]))
    else $error("channel 0 not NFA byte");

  cov_payload: cover property (step && payload && in_ts16 && ccs);
  cov_metal_remote: cover property (step && metal && remote);
  cov_write_apply: cover property (wr_code ##[1:300] (ce && frame_end));
endmodule : e1c_ctrl
`default_nettype wire

//--- e1c_line_model.sv
// Line interface and backplane model with bit counters
`timescale 1ns/1ps
`default_nettype none
module e1c_line_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  input wire logic rx_marks,
  input wire logic bp_level,
  input wire logic tx_line_pos,
  input wire logic tx_line_neg,
  input wire logic backplane_data_out,
  output logic bit_strobe,
  output logic rx_line_pos,
  output logic rx_line_neg,
  output logic backplane_data_in,
  output logic [31:0] bits,
  output logic [31:0] tx_ones,
  output logic [31:0] bp_ones,
  output logic [31:0] tx_viol
);
  logic [1:0] div;
  logic phase;
  logic last_neg;
  wire logic mark;
  wire logic run;
  wire logic viol;
  assign mark = tx_line_pos | tx_line_neg;
  assign run = bit_strobe & (bits != 32'h00000200);
  assign viol = mark & (tx_line_neg == last_neg);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= 2'h0;
      bit_strobe <= 1'b0;
      phase <= 1'b0;
      rx_line_pos <= 1'b0;
      rx_line_neg <= 1'b0;
      backplane_data_in <= 1'b0;
      last_neg <= 1'b0;
    end else begin
      div <= div + 2'h1;
      bit_strobe <= (div == 2'h3);
      if (bit_strobe) begin
        // Alternating marks, or no pulses when idle
        phase <= ~phase;
        rx_line_pos <= rx_marks & phase;
        rx_line_neg <= rx_marks & ~phase;
        backplane_data_in <= bp_level;
        if (mark) last_neg <= tx_line_neg;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn || clr) begin
      bits <= 32'h0;
      tx_ones <= 32'h0;
      bp_ones <= 32'h0;
      tx_viol <= 32'h0;
    end else if (run) begin
      bits <= bits + 32'h1;
      tx_ones <= tx_ones + {31'h0, mark};
      bp_ones <= bp_ones + {31'h0, backplane_data_out};
      tx_viol <= tx_viol + {31'h0, viol};
    end
  end
endmodule : e1c_line_model
`default_nettype wire

//--- e1_coding_loopback_nfa_control_test.sv
// Self-checking bench for the E1 coding, loopback and channel 0 block
`timescale 1ns/1ps
`default_nettype none
module e1_coding_loopback_nfa_control_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic clr = 1'b0;
  logic rx_marks = 1'b0;
  logic bp_level = 1'b0;
  logic [31:0] prdata, rd, bits, tx_ones, bp_ones, tx_viol;
  logic pready, pslverr, er, bit_strobe, rx_line_pos, rx_line_neg;
  logic tx_line_pos, tx_line_neg, backplane_data_in, backplane_data_out;
  int bad_count = 0;
  int checked = 0;
  always #5 pclk = ~pclk;
  e1c_ctrl dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bit_strobe(bit_strobe),
    .rx_line_pos(rx_line_pos), .rx_line_neg(rx_line_neg), .tx_line_pos(tx_line_pos),
    .tx_line_neg(tx_line_neg), .backplane_data_in(backplane_data_in),
    .backplane_data_out(backplane_data_out), .tx_ch16_data(1'b0), .dl_data(1'b0));
  e1c_line_model partner (.pclk(pclk), .presetn(presetn), .clr(clr),
    .rx_marks(rx_marks), .bp_level(bp_level), .tx_line_pos(tx_line_pos),
    .tx_line_neg(tx_line_neg), .backplane_data_out(backplane_data_out),
    .bit_strobe(bit_strobe), .rx_line_pos(rx_line_pos), .rx_line_neg(rx_line_neg),
    .backplane_data_in(backplane_data_in), .bits(bits), .tx_ones(tx_ones),
    .bp_ones(bp_ones), .tx_viol(tx_viol));
  task end_of_test;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task hang(input string what);
    bad_count++;
    $display("BAD %s expected done seen timeout", what);
    end_of_test();
  endtask : hang
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) hang("apb ready");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wait_apply;
    int n;
    n = 0;
    do begin
      apb(1'b0, e1c_pkg::ADDR_STAT, 32'h0);
      n++;
    end while (rd[e1c_pkg::STAT_PEND] !== 1'b0 && n < 1000);
    if (n >= 1000) hang("apply");
  endtask : wait_apply
  task count;
    int n;
    n = 0;
    @(posedge pclk);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    @(posedge pclk);
    while (bits != 32'h00000200 && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 5000) hang("bit count");
  endtask : count
  task cfg(input logic [7:0] code, nfa, aux, input logic marks, level);
    apb(1'b1, e1c_pkg::ADDR_CODE, {24'h0, code});
    rx_marks <= marks;
    bp_level <= level;
    apb(1'b1, e1c_pkg::ADDR_NFA, {24'h0, nfa});
    apb(1'b1, e1c_pkg::ADDR_AUX, {24'h0, aux});
    wait_apply();
    count();
    count();
  endtask : cfg
  task t_regs;
    logic [7:0] a [4];
    logic [7:0] m [3];
    a = '{e1c_pkg::ADDR_CODE, e1c_pkg::ADDR_NFA, e1c_pkg::ADDR_AUX, e1c_pkg::ADDR_STAT};
    m = '{e1c_pkg::CODE_MASK, e1c_pkg::NFA_MASK, e1c_pkg::AUX_MASK};
    foreach (a[i]) begin
      apb(1'b0, a[i], 32'h0);
      chk("reset value", 32'h0, rd);
    end
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, a[i], 32'hffffffff);
      apb(1'b0, a[i], 32'h0);
      chk("stored bits", {24'h0, m[i]}, rd);
    end
    apb(1'b0, e1c_pkg::ADDR_STAT, 32'h0);
    chk("status pending", 32'h00000001, rd);
    wait_apply();
    chk("status active", 32'h7f7fef00, rd);
    apb(1'b0, 8'h00, 32'h0);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped error", 32'h1, {31'h0, er});
    $display("test regs done");
  endtask : t_regs
  task t_txcode;
    cfg(8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
    chk("ami marks", 32'h00000007, tx_ones);
    chk("ami violations", 32'h0, tx_viol);
    cfg(8'h20, 8'h00, 8'h00, 1'b0, 1'b0);
    chk("hdb3 violations", 32'h1, {31'h0, tx_viol != 32'h0});
    $display("test tx coding done");
  endtask : t_txcode
  task t_metal;
    cfg(8'h40, 8'h00, 8'h00, 1'b1, 1'b1);
    chk("metal ami", 32'h000001e7, bp_ones);
    cfg(8'he0, 8'h00, 8'h00, 1'b1, 1'b1);
    chk("metal hdb3", 32'h000001e7, bp_ones);
    cfg(8'h60, 8'h00, 8'h00, 1'b1, 1'b1);
    chk("metal mismatch", 32'h1, {31'h0, bp_ones > 32'h000001e7});
    $display("test metallic done");
  endtask : t_metal
  task t_remote;
    cfg(8'h04, 8'h00, 8'h00, 1'b1, 1'b0);
    chk("remote marks", 32'h00000200, tx_ones);
    chk("remote violations", 32'h0, tx_viol);
    $display("test remote done");
  endtask : t_remote
  task t_payload;
    cfg(8'h01, 8'h00, 8'h00, 1'b1, 1'b0);
    chk("payload cas", 32'h000001e7, tx_ones);
    cfg(8'h01, 8'h00, 8'h20, 1'b1, 1'b0);
    chk("payload ccs", 32'h000001f7, tx_ones);
    $display("test payload done");
  endtask : t_payload
  task t_bplane;
    cfg(8'h00, 8'h00, 8'h00, 1'b0, 1'b1);
    chk("no loop out", 32'h0, bp_ones);
    cfg(8'h02, 8'h00, 8'h00, 1'b0, 1'b1);
    chk("backplane loop", 32'h00000200, bp_ones);
    $display("test backplane done");
  endtask : t_bplane
  task t_digital;
    logic [7:0] dn [7];
    logic [7:0] da [7];
    logic [31:0] de [7];
    dn = '{8'h00, 8'h1f, 8'h3f, 8'h3f, 8'h3f, 8'h7f, 8'h20};
    da = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h5f, 8'h40, 8'h60};
    de = '{32'h1e7, 32'h1ec, 32'h1ec, 32'h1ed, 32'h1e8, 32'h1f0, 32'h1f8};
    foreach (dn[i]) begin
      cfg(8'h08, dn[i], da[i], 1'b1, 1'b1);
      chk("digital ones", de[i], bp_ones);
    end
    $display("test digital done");
  endtask : t_digital
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_txcode();
    t_metal();
    t_remote();
    t_payload();
    t_bplane();
    t_digital();
    end_of_test();
  end
endmodule : e1_coding_loopback_nfa_control_test
`default_nettype wire
